// ---- bsd_regs.svh ----
/*
 * Register offsets, field positions, reset values and fixed constants of the
 * backlight status and dimming register slice.
 * Assumes a 9-bit word address and 10-bit register data.
 */
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH

// ==========================================
// Status window
`define BSD_STAT_FIRST 9'h100
`define BSD_STAT_LAST 9'h117
`define BSD_FLAGS 9'h100
`define BSD_ACT_LOW 9'h101
`define BSD_ACT_MID 9'h102
`define BSD_ACT_HIGH 9'h103
`define BSD_SHORT_IDX 9'h104
`define BSD_TRIM_FIRST 9'h105
`define BSD_TRIM_LAST 9'h114
`define BSD_OPEN_IDX 9'h115
`define BSD_FB1 9'h116
`define BSD_FB2 9'h117

// ==========================================
// Frame based controls and video standard select
`define BSD_MODE_REG 9'h130
`define BSD_BRI_FIRST 9'h140
`define BSD_BRI_LAST 9'h15F
`define BSD_MODE_STYLE 0
`define BSD_MODE_COMP 1
`define BSD_MODE_FAC_LSB 2
`define BSD_MODE_STD_LSB 5

// ==========================================
// Reset values and derate divisor
`define BSD_BRI_RST 10'h066
`define BSD_FAC_RST 3'h7
`define BSD_CT_RST 7'h64
`define BSD_DUTY_RST 10'h008
`define BSD_STD_RST 2'h0
`define BSD_CT_BASE 7'h4F
`define BSD_CT_STEP 7'h03
`define BSD_CT_UNITY 17'h00064
`define BSD_HZ_NTSC 9'h078
`define BSD_HZ_PAL 9'h064
`define BSD_HZ_GAME 9'h060

`endif

// ---- bsd_pkg.sv ----
/*
 * Types of the backlight status and dimming register slice.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bsd_pkg;

    typedef enum logic [2:0] {
        BSD_STD_NTSC = 3'h1,
        BSD_STD_PAL = 3'h2,
        BSD_STD_GAME = 3'h4
    } bsd_std_t;

    typedef struct packed {
        logic overheat_flag;
        logic open_flag;
        logic short_flag;
        logic init_done;
        logic cali_done;
        logic [31:0] channel_active_bits;
        logic [4:0] short_idx;
        logic [4:0] open_idx;
        logic [31:0][3:0] sink_current_trim;
        logic [7:0] converter_feedback_code1;
        logic [7:0] converter_feedback_code2;
    } bsd_status_t;

    typedef struct packed {
        logic dimming_style;
        logic thermal_comp_enable;
        logic [6:0] derate_divisor;
        bsd_std_t video_standard;
        logic [8:0] vsync_base_hz;
    } bsd_ctrl_t;

endpackage : bsd_pkg

// ---- bsd_regs.sv ----
/*
 * Register slice of a 32-channel backlight driver: status read-back,
 * frame-paced dimming controls and video standard selection.
 * Assumes a deserialised register port on the core clock and a frame sync
 * pin from outside that clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bsd_regs.svh"

module bsd_regs (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Register port
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [8:0] i_addr,
    input wire logic [9:0] i_wdata,
    output logic [9:0] o_rdata,
    output logic o_rd_valid,
    // Frame sync pin
    input wire logic i_vsync,
    // Internal status
    input wire bsd_pkg::bsd_status_t i_status,
    // Applied controls
    output bsd_pkg::bsd_ctrl_t o_ctrl,
    output logic [31:0][9:0] o_duty
);

    // ==========================================
    // State
    typedef struct packed {
        logic vs1;
        logic vs2;
        logic vs3;
        logic sh_style;
        logic sh_comp;
        logic [2:0] sh_fac;
        logic [1:0] sh_std;
        logic [31:0][9:0] sh_bri;
        bsd_pkg::bsd_ctrl_t ctrl;
        logic [31:0][9:0] duty;
        logic [9:0] rdata;
        logic rvalid;
    } bsd_state_t;

    bsd_state_t s_reg;
    bsd_state_t s_next;

    // Gamma-like breakpoints, 64 codes per segment
    localparam logic [16:0][9:0] BSD_LUT = {
        10'h3FF, 10'h320, 10'h26C, 10'h1F4, 10'h190, 10'h140, 10'h100, 10'h0D0,
        10'h0A6, 10'h080, 10'h060, 10'h044, 10'h02C, 10'h01A, 10'h00C, 10'h004,
        10'h000
    };

    // ==========================================
    // Duty computation
    // Table lookup
    function automatic logic [9:0] bsd_lut(input logic [9:0] bri);
        logic [4:0] idx;
        logic [9:0] lo;
        logic [9:0] hi;
        logic [15:0] step;
        idx = {1'b0, bri[9:6]};
        lo = BSD_LUT[idx];
        hi = BSD_LUT[idx + 5'h01];
        step = 16'((hi - lo) * bri[5:0]);
        return 10'(lo + step[15:6]);
    endfunction : bsd_lut

    function automatic logic [6:0] bsd_ct(input logic [2:0] fac);
        return 7'(`BSD_CT_BASE + `BSD_CT_STEP * fac);
    endfunction : bsd_ct

    function automatic logic [9:0] bsd_comp(input logic [9:0] d, input logic [2:0] fac);
        logic [16:0] q;
        q = 17'((17'(d) * `BSD_CT_UNITY) / 17'(bsd_ct(fac)));
        return (q > 17'h003FF) ? 10'h3FF : q[9:0];
    endfunction : bsd_comp

    logic vs_rise;
    logic [31:0][9:0] lut_w;

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            lut_w[i] = bsd_lut(s_reg.sh_bri[i]);
        end
    end

    // The second and third synchroniser stages feed the edge detector
    assign vs_rise = s_reg.vs2 & ~s_reg.vs3;

    // ==========================================
    // Next state
    always_comb begin
        logic [4:0] ti;
        s_next = s_reg;
        ti = 5'h00;
        s_next.vs1 = i_vsync;
        s_next.vs2 = s_reg.vs1;
        s_next.vs3 = s_reg.vs2;

        // Host writes land in shadows; status window writes fall through
        if (i_wr_en) begin
            if (i_addr == `BSD_MODE_REG) begin
                s_next.sh_style = i_wdata[`BSD_MODE_STYLE];
                s_next.sh_comp = i_wdata[`BSD_MODE_COMP];
                s_next.sh_fac = i_wdata[`BSD_MODE_FAC_LSB +: 3];
                s_next.sh_std = i_wdata[`BSD_MODE_STD_LSB +: 2];
            end else if (i_addr >= `BSD_BRI_FIRST && i_addr <= `BSD_BRI_LAST) begin
                s_next.sh_bri[i_addr[4:0]] = i_wdata;
            end
        end

        // NTSC for codes 0 and 3
        case (s_reg.sh_std)
            2'h1: begin
                s_next.ctrl.video_standard = bsd_pkg::BSD_STD_PAL;
                s_next.ctrl.vsync_base_hz = `BSD_HZ_PAL;
            end
            2'h2: begin
                s_next.ctrl.video_standard = bsd_pkg::BSD_STD_GAME;
                s_next.ctrl.vsync_base_hz = `BSD_HZ_GAME;
            end
            default: begin
                s_next.ctrl.video_standard = bsd_pkg::BSD_STD_NTSC;
                s_next.ctrl.vsync_base_hz = `BSD_HZ_NTSC;
            end
        endcase

        if (vs_rise) begin
            s_next.ctrl.dimming_style = s_reg.sh_style;
            s_next.ctrl.thermal_comp_enable = s_reg.sh_comp;
            s_next.ctrl.derate_divisor = bsd_ct(s_reg.sh_fac);
            for (int i = 0; i < 32; i++) begin
                s_next.duty[i] = s_reg.sh_comp ? bsd_comp(lut_w[i], s_reg.sh_fac) : lut_w[i];
            end
        end

        s_next.rvalid = i_rd_en;
        s_next.rdata = 10'h000;
        if (i_rd_en) begin
            if (i_addr >= `BSD_TRIM_FIRST && i_addr <= `BSD_TRIM_LAST) begin
                ti = 5'(i_addr - `BSD_TRIM_FIRST);
                s_next.rdata = {2'h0, i_status.sink_current_trim[{ti[3:0], 1'b1}],
                    i_status.sink_current_trim[{ti[3:0], 1'b0}]};
            end else if (i_addr >= `BSD_BRI_FIRST && i_addr <= `BSD_BRI_LAST) begin
                s_next.rdata = s_reg.sh_bri[i_addr[4:0]];
            end else begin
                case (i_addr)
                    `BSD_FLAGS: s_next.rdata = {4'h0, i_status.cali_done, i_status.init_done, 1'b0,
                        i_status.short_flag, i_status.open_flag, i_status.overheat_flag};
                    `BSD_ACT_LOW: s_next.rdata = i_status.channel_active_bits[9:0];
                    `BSD_ACT_MID: s_next.rdata = i_status.channel_active_bits[19:10];
                    `BSD_ACT_HIGH: s_next.rdata = i_status.channel_active_bits[29:20];
                    `BSD_SHORT_IDX: s_next.rdata = {1'b0, i_status.short_idx, 2'h0,
                        i_status.channel_active_bits[31:30]};
                    `BSD_OPEN_IDX: s_next.rdata = {5'h00, i_status.open_idx};
                    `BSD_FB1: s_next.rdata = {2'h0, i_status.converter_feedback_code1};
                    `BSD_FB2: s_next.rdata = {2'h0, i_status.converter_feedback_code2};
                    `BSD_MODE_REG: s_next.rdata = {3'h0, s_reg.sh_std, s_reg.sh_fac,
                        s_reg.sh_comp, s_reg.sh_style};
                    default: s_next.rdata = 10'h000;
                endcase
            end
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s_reg.vs1 <= 1'b0;
            s_reg.vs2 <= 1'b0;
            s_reg.vs3 <= 1'b0;
            s_reg.sh_style <= 1'b0;
            s_reg.sh_comp <= 1'b0;
            s_reg.sh_fac <= `BSD_FAC_RST;
            s_reg.sh_std <= `BSD_STD_RST;
            s_reg.sh_bri <= {32{`BSD_BRI_RST}};
            s_reg.ctrl.dimming_style <= 1'b0;
            s_reg.ctrl.thermal_comp_enable <= 1'b0;
            s_reg.ctrl.derate_divisor <= `BSD_CT_RST;
            s_reg.ctrl.video_standard <= bsd_pkg::BSD_STD_NTSC;
            s_reg.ctrl.vsync_base_hz <= `BSD_HZ_NTSC;
            // Table of the reset brightness, so the first frame brings no jump
            s_reg.duty <= {32{`BSD_DUTY_RST}};
            s_reg.rdata <= 10'h000;
            s_reg.rvalid <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata = s_reg.rdata;
    assign o_rd_valid = s_reg.rvalid;
    assign o_ctrl = s_reg.ctrl;
    assign o_duty = s_reg.duty;

    // ==========================================
    // Checks
    default clocking bsd_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence bsd_frame_edge;
        s_reg.vs2 && !s_reg.vs3;
    endsequence

    sequence bsd_quiet;
        !(s_reg.vs2 && !s_reg.vs3);
    endsequence

    sequence bsd_rd_req;
        i_rd_en;
    endsequence

    sequence bsd_bri_write;
        i_wr_en && i_addr >= `BSD_BRI_FIRST && i_addr <= `BSD_BRI_LAST;
    endsequence

    a_frame_hold: assert property (bsd_quiet |=> $stable(o_ctrl.dimming_style) && $stable(o_duty))
        else $error("controls changed without frame sync");
    a_style_apply: assert property (bsd_frame_edge |=> o_ctrl.dimming_style == $past(s_reg.sh_style))
        else $error("dimming style not applied at frame");
    a_comp_off: assert property (bsd_frame_edge and !s_reg.sh_comp |=> o_duty[0] == $past(lut_w[0]))
        else $error("duty altered with compensation off");
    a_comp_div: assert property (bsd_frame_edge and s_reg.sh_comp |=> o_duty[5] >= $past(lut_w[5]))
        else $error("compensated duty below requested duty");
    a_divisor_map: assert property (o_ctrl.derate_divisor == 7'h4F + 7'h03 * $past(s_reg.sh_fac, 1)
        || !$past(vs_rise))
        else $error("derate divisor does not match factor");
    a_bri_reset: assert property ($fell(i_rst) |-> s_reg.sh_bri[31] == 10'h066 && s_reg.sh_fac == 3'h7)
        else $error("brightness reset value wrong");
    a_std_ntsc: assert property ((s_reg.sh_std == 2'h0 || s_reg.sh_std == 2'h3) |=> o_ctrl.vsync_base_hz == 9'h078)
        else $error("NTSC frame base wrong");
    a_std_pal: assert property (s_reg.sh_std == 2'h1 |=> o_ctrl.video_standard == bsd_pkg::BSD_STD_PAL)
        else $error("PAL not selected");
    a_std_game: assert property (s_reg.sh_std == 2'h2 |=> o_ctrl.vsync_base_hz == 9'h060)
        else $error("game frame base wrong");
    a_status_ro: assert property (i_wr_en && i_addr >= 9'h100 && i_addr <= 9'h117
        |=> $stable(s_reg.sh_bri) && $stable(s_reg.sh_fac))
        else $error("status write changed state");
    a_lut_curve: assert property (s_reg.sh_bri[0] == 10'h200 |-> lut_w[0] == 10'h0A6)
        else $error("brightness table midpoint wrong");

    // Read answer stands one cycle; idle data is zero so stale reads never leak
    a_read_pulse: assert property (bsd_rd_req |=> o_rd_valid)
        else $error("read not answered next cycle");
    a_read_idle: assert property (!i_rd_en |=> !o_rd_valid && o_rdata == 10'h000)
        else $error("read data shown without a read");
    a_status_live: assert property (bsd_rd_req ##0 (i_addr == `BSD_FB1)
        |=> o_rdata == {2'h0, $past(i_status.converter_feedback_code1)})
        else $error("feedback code not read live");

    // Frame gated controls
    a_comp_apply: assert property (bsd_frame_edge |=> o_ctrl.thermal_comp_enable == $past(s_reg.sh_comp))
        else $error("compensation enable not applied at frame");
    a_comp_hold: assert property (bsd_quiet
        |=> $stable(o_ctrl.thermal_comp_enable) && $stable(o_ctrl.derate_divisor))
        else $error("compensation changed without frame sync");
    a_comp_unity: assert property (bsd_frame_edge and s_reg.sh_comp && s_reg.sh_fac == 3'h7
        |=> o_duty[5] == $past(lut_w[5]))
        else $error("unity divisor changed the duty");
    a_comp_exact: assert property (bsd_frame_edge and s_reg.sh_comp && s_reg.sh_fac == 3'h0
        && s_reg.sh_bri[0] == 10'h200 |=> o_duty[0] == 10'h0D2)
        else $error("compensated duty wrong for factor code 0");

    // Brightness shadows move only on their own writes
    a_bri_first: assert property (bsd_bri_write ##0 (i_addr == `BSD_BRI_FIRST)
        |=> s_reg.sh_bri[0] == $past(i_wdata))
        else $error("brightness write lost");
    a_bri_hold: assert property (!(i_wr_en && i_addr >= `BSD_BRI_FIRST && i_addr <= `BSD_BRI_LAST)
        |=> $stable(s_reg.sh_bri))
        else $error("brightness changed without a write");

    // Video standard decode
    a_std_code3: assert property (s_reg.sh_std == 2'h3 |=> o_ctrl.video_standard == bsd_pkg::BSD_STD_NTSC)
        else $error("code 3 not NTSC");
    a_game_sel: assert property (s_reg.sh_std == 2'h2 |=> o_ctrl.video_standard == bsd_pkg::BSD_STD_GAME)
        else $error("game standard not selected");
    a_pal_rate: assert property (s_reg.sh_std == 2'h1 |=> o_ctrl.vsync_base_hz == 9'h064)
        else $error("PAL frame base wrong");

    // Reset state of the applied controls
    a_ctrl_reset: assert property ($fell(i_rst) |-> !o_ctrl.dimming_style && !o_ctrl.thermal_comp_enable
        && o_ctrl.derate_divisor == 7'h64)
        else $error("applied controls wrong after reset");
    a_duty_reset: assert property ($fell(i_rst) |-> o_duty[31] == lut_w[31])
        else $error("reset duty differs from table of reset brightness");

endmodule : bsd_regs
`default_nettype wire

// ---- bsd_host_frame.sv ----
/*
 * Host side frame sync source for the backlight register slice bench.
 * Assumes the bench calls frame() from its main sequence only.
 */
`timescale 1ns/10ps
`default_nettype none

module bsd_host_frame (
    // Clock
    input wire logic i_ref_clk,
    // Frame sync pin
    output logic o_vsync
);
    // ==========================================
    // Frame sync pulses
    initial o_vsync = 1'b0;

    // slow frame pacing
    // Wide pulses and gaps keep every edge well past the sync stages
    task automatic frame();
        @(posedge i_ref_clk);
        #1 o_vsync = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #1 o_vsync = 1'b0;
        repeat (6) @(posedge i_ref_clk);
        #1;
    endtask : frame
endmodule : bsd_host_frame

`default_nettype wire

// ---- bsd_regs_bench.sv ----
/*
 * Self-checking bench of the backlight status and dimming register slice.
 * Assumes the design and its frame sync partner are compiled beforehand.
 */
`timescale 1ns/10ps
`default_nettype none

module bsd_regs_bench;
    // ==========================================
    // Signals
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic [8:0] i_addr = 9'h000;
    logic [9:0] i_wdata = 10'h000;
    bsd_pkg::bsd_status_t st;
    logic [9:0] o_rdata;
    logic o_rd_valid;
    logic vsync;
    bsd_pkg::bsd_ctrl_t o_ctrl;
    logic [31:0][9:0] o_duty;
    int bad_count = 0;
    int tests_run = 0;
    logic [2:0] std_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
    logic [8:0] hz_tab [4] = '{9'h078, 9'h064, 9'h060, 9'h078};

    always #4 i_ref_clk = ~i_ref_clk;

    bsd_host_frame u_host (.i_ref_clk(i_ref_clk), .o_vsync(vsync));

    bsd_regs u_dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
        .i_vsync(vsync), .i_status(st), .o_ctrl(o_ctrl), .o_duty(o_duty)
    );

    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [8:0] a, input logic [9:0] d);
        @(posedge i_ref_clk);
        #1 i_wr_en = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(posedge i_ref_clk);
        #1 i_wr_en = 1'b0;
    endtask : reg_wr

    // Valid is a one-cycle pulse, so it is looked at right after the read edge
    task automatic reg_rd(input logic [8:0] a, input logic [9:0] exp);
        @(posedge i_ref_clk);
        #1 i_rd_en = 1'b1;
        i_addr = a;
        @(posedge i_ref_clk);
        #1 i_rd_en = 1'b0;
        check(o_rd_valid, 1'b1);
        check(o_rdata, exp);
    endtask : reg_rd

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // ==========================================
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end

    // ==========================================
    // Main sequence
    initial begin
        st = '0;
        st.overheat_flag = 1'b1;
        st.open_flag = 1'b1;
        st.short_flag = 1'b1;
        st.init_done = 1'b1;
        st.cali_done = 1'b1;
        st.channel_active_bits = 32'hC00002A5;
        st.short_idx = 5'h15;
        st.open_idx = 5'h0E;
        st.sink_current_trim[0] = 4'h5;
        st.sink_current_trim[1] = 4'hA;
        st.converter_feedback_code1 = 8'hC3;
        st.converter_feedback_code2 = 8'h3C;
        repeat (12) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        check(o_ctrl.dimming_style, 1'b0);
        check(o_ctrl.thermal_comp_enable, 1'b0);
        check(o_ctrl.derate_divisor, 7'h64);
        check(o_ctrl.video_standard, bsd_pkg::BSD_STD_NTSC);
        check(o_ctrl.vsync_base_hz, 9'h078);
        check(o_duty[31], 10'h008);
        reg_rd(9'h130, 10'h01C);
        reg_rd(9'h140, 10'h066);
        reg_rd(9'h15F, 10'h066);
        reg_rd(9'h100, 10'h037);
        reg_wr(9'h101, 10'h3FF);
        reg_rd(9'h101, 10'h2A5);
        reg_rd(9'h104, 10'h153);
        reg_rd(9'h105, 10'h0A5);
        reg_rd(9'h115, 10'h00E);
        reg_rd(9'h116, 10'h0C3);
        reg_rd(9'h117, 10'h03C);
        reg_rd(9'h000, 10'h000);
        reg_wr(9'h140, 10'h200);
        reg_rd(9'h140, 10'h200);
        reg_wr(9'h130, 10'h003);
        check(o_ctrl.dimming_style, 1'b0);
        check(o_duty[1], 10'h008);
        u_host.frame();
        check(o_ctrl.dimming_style, 1'b1);
        check(o_ctrl.thermal_comp_enable, 1'b1);
        check(o_duty[1], 10'h00A);
        check(o_duty[0], 10'h0D2);
        for (int k = 0; k < 8; k++) begin
            reg_wr(9'h130, {3'h0, 2'h0, k[2:0], 2'b10});
            u_host.frame();
            check(o_ctrl.derate_divisor, 79 + 3 * k);
        end
        reg_wr(9'h130, 10'h000);
        u_host.frame();
        check(o_duty[1], 10'h008);
        check(o_duty[0], 10'h0A6);
        // Standard follows the shadow without waiting for a frame
        for (int k = 0; k < 4; k++) begin
            reg_wr(9'h130, {3'h0, k[1:0], 3'h7, 2'b00});
            repeat (2) @(posedge i_ref_clk);
            #1;
            check(o_ctrl.video_standard, std_tab[k]);
            check(o_ctrl.vsync_base_hz, hz_tab[k]);
        end
        give_verdict();
    end
endmodule : bsd_regs_bench

`default_nettype wire
